//--- logic/drsc_pkg.sv
// package for the disk read, check and scan command logic
package drsc_pkg;
  localparam logic [3:0] OP_READ = 4'hB;
  localparam logic [3:0] OP_CHECK = 4'hC;
  localparam logic [3:0] OP_SCAN = 4'hD;
  // register offsets on the command port
  localparam logic [3:0] A_CMD = 4'h0;
  localparam logic [3:0] A_MARK = 4'h1;
  localparam logic [3:0] A_CYLH = 4'h2;
  localparam logic [3:0] A_CYLL = 4'h3;
  localparam logic [3:0] A_HEAD = 4'h4;
  localparam logic [3:0] A_SECT = 4'h5;
  localparam logic [3:0] A_SECTORS_REMAINING = 4'h6;
  localparam logic [3:0] A_LTRK = 4'h7;
  localparam logic [3:0] A_LSEC = 4'h8;
  localparam logic [3:0] A_MODE = 4'h9;
  localparam logic [3:0] A_EST = 4'hA;
  localparam logic [3:0] A_STAT = 4'hB;
  // error status byte bit positions
  localparam int EB_EOC = 7;
  localparam int EB_EQC = 6;
  localparam int EB_NR = 5;
  localparam int EB_DER = 4;
  localparam int EB_OVR = 3;
  localparam int EB_ND = 2;
  localparam int EB_MDM = 1;
  // controller status bits
  localparam int SB_BUSY = 0;
  localparam int SB_DONE = 1;
  localparam int SB_ABN = 2;
  localparam int SB_RRQ = 3;
  localparam int SB_MIS = 4;
  // mode bits
  localparam int MB_ECC = 0;
  localparam int MB_SOFT = 1;
  // index pulse limits
  localparam logic [1:0] IDX_SYNC_LIM = 2'h3;
  localparam logic [1:0] IDX_FIND_LIM = 2'h2;
  localparam logic [7:0] SCAN_TC_BYTE = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  typedef enum {ST_IDLE, ST_SEEK, ST_DATA, ST_CHK, ST_ADV} drsc_state_t;
endpackage

//--- logic/drsc_core.sv
// read, check and scan command execution for a disk controller
`timescale 1ns/1ps
module drsc_core
  import drsc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // drive, from pins
  input wire logic drv_ready_i,
  input wire logic drv_fault_i,
  input wire logic index_pulse_i,
  output logic [1:0] unit_select_o,
  output logic [7:0] physical_head_number_o,
  // format controller events, same clock
  input wire logic id_mark_seen_i,
  input wire logic id_match_i,
  input wire logic data_mark_miss_i,
  input wire logic disk_byte_vld_i,
  input wire logic [7:0] disk_byte_i,
  input wire logic sector_end_i,
  input wire logic crc_err_i,
  input wire logic ecc_err_i,
  input wire logic ecc_correctable_i,
  input wire logic fifo_full_i,
  // dma side
  output logic dma_req_o,
  input wire logic dma_ack_i,
  input wire logic [7:0] dma_rdata_i,
  output logic [7:0] dma_wdata_o,
  input wire logic transfer_count_done_i,
  // sector search request to format controller
  output logic seek_sector_o
);
  drsc_state_t st_r, st_nxt;
  logic [7:0] mark_r, cylh_r, cyll_r, head_r, sect_r, sectors_remaining_r;
  logic [7:0] ltrk_r, lsec_r, mode_r, est_r, stat_r, rdata_r;
  logic [3:0] op_r;
  logic [1:0] unit_r, idx_cnt_r;
  logic tc_r, mis_r, dwr_r;
  logic [7:0] dwdata_r;
  logic [2:0] rdy_s, flt_s, idx_s;

  function automatic logic [7:0] err_bit(input int pos);
    err_bit = 8'h01 << pos;
  endfunction

  // pin inputs pass three flops; only the second and the third stage are read
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rdy_s <= 3'h0;
      flt_s <= 3'h0;
      idx_s <= 3'h0;
    end else begin
      rdy_s <= {rdy_s[1:0], drv_ready_i};
      flt_s <= {flt_s[1:0], drv_fault_i};
      idx_s <= {idx_s[1:0], index_pulse_i};
    end
  end
  wire rdy = rdy_s[1];
  wire flt = flt_s[1];
  wire idx_rise = idx_s[1] & ~idx_s[2];

  wire busy = st_r != ST_IDLE;
  wire is_scan = op_r == OP_SCAN;
  wire is_read = op_r == OP_READ;
  wire go_cmd = reg_wr_i && reg_addr_i == A_CMD && !busy;
  wire op_ok = reg_wdata_i[7:4] == OP_READ || reg_wdata_i[7:4] == OP_CHECK
    || reg_wdata_i[7:4] == OP_SCAN;
  wire par_wr = reg_wr_i && !busy;
  // limits are compared after the increment, so the limit value itself is
  // never used as a sector or head index
  wire [7:0] sect_inc = sect_r + 8'h01;
  wire [7:0] head_inc = head_r + 8'h01;
  wire last_sec = sect_inc == lsec_r;
  wire last_trk = head_inc == ltrk_r;
  wire ecc_mode = mode_r[MB_ECC];
  // compare byte: memory data, or 00 once terminal count seen
  wire [7:0] cmp_byte = tc_r ? SCAN_TC_BYTE : dma_rdata_i;
  wire byte_in = st_r == ST_DATA && disk_byte_vld_i;

  // error evaluation in priority order
  logic [7:0] err_set;
  logic abn, fin_ok;
  always_comb begin
    err_set = RST_BYTE;
    abn = 1'b0;
    fin_ok = 1'b0;
    if (busy && !rdy) begin
      err_set = err_bit(EB_NR);
      abn = 1'b1;
    end else if (st_r == ST_DATA && flt) begin
      err_set = err_bit(EB_EQC);
      abn = 1'b1;
    end else if (st_r == ST_SEEK && idx_rise && !id_mark_seen_i
                 && idx_cnt_r == IDX_SYNC_LIM - 2'h1) begin
      abn = 1'b1;
    end else if (st_r == ST_SEEK && idx_rise
                 && idx_cnt_r == IDX_FIND_LIM - 2'h1 && id_mark_seen_i) begin
      err_set = err_bit(EB_ND);
      abn = 1'b1;
    end else if (st_r == ST_DATA && data_mark_miss_i) begin
      err_set = err_bit(EB_MDM);
      abn = 1'b1;
    end else if (byte_in && fifo_full_i && !dma_ack_i && is_read
                 && !tc_r) begin
      err_set = err_bit(EB_OVR);
      abn = 1'b1;
    end else if (st_r == ST_CHK && ecc_mode && ecc_err_i) begin
      err_set = err_bit(EB_DER);
      // check command only detects, never corrects
      abn = !(ecc_correctable_i && is_read);
      fin_ok = !abn;
    end else if (st_r == ST_CHK && !ecc_mode && crc_err_i) begin
      err_set = err_bit(EB_DER);
      abn = 1'b1;
    end
  end

  wire rrq_evt = st_r == ST_SEEK && idx_rise && !id_mark_seen_i
    && idx_cnt_r == IDX_SYNC_LIM - 2'h1 && rdy;
  wire scan_hit = st_r == ST_CHK && is_scan && !mis_r;
  wire cnt_last = sectors_remaining_r == 8'h01;
  wire eoc = last_sec && last_trk && !cnt_last;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: if (go_cmd && op_ok) st_nxt = ST_SEEK;
      ST_SEEK: if (abn) st_nxt = ST_IDLE;
               else if (id_match_i) st_nxt = ST_DATA;
      ST_DATA: if (abn) st_nxt = ST_IDLE;
               else if (sector_end_i) st_nxt = ST_CHK;
      ST_CHK: if (abn || fin_ok || scan_hit) st_nxt = ST_IDLE;
              else st_nxt = ST_ADV;
      ST_ADV: if (cnt_last || eoc) st_nxt = ST_IDLE;
              else st_nxt = ST_SEEK;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) st_r <= ST_IDLE;
    else st_r <= st_nxt;
  end

  // index pulse counter for the sector search
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || st_r != ST_SEEK) idx_cnt_r <= 2'h0;
    else if (idx_rise) idx_cnt_r <= idx_cnt_r + 2'h1;
  end

  // command, parameters and sector advance
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      op_r <= 4'h0;
      unit_r <= 2'h0;
      {mark_r, cylh_r, cyll_r, head_r, sect_r, sectors_remaining_r} <= {6{RST_BYTE}};
      {ltrk_r, lsec_r, mode_r} <= {3{RST_BYTE}};
    end else begin
      if (go_cmd && op_ok) begin
        op_r <= reg_wdata_i[7:4];
        unit_r <= reg_wdata_i[1:0];
      end
      if (par_wr) begin
        case (reg_addr_i)
          A_MARK: mark_r <= reg_wdata_i;
          A_CYLH: cylh_r <= reg_wdata_i;
          A_CYLL: cyll_r <= reg_wdata_i;
          A_HEAD: head_r <= reg_wdata_i;
          A_SECT: sect_r <= reg_wdata_i;
          A_SECTORS_REMAINING: sectors_remaining_r <= reg_wdata_i;
          A_LTRK: ltrk_r <= reg_wdata_i;
          A_LSEC: lsec_r <= reg_wdata_i;
          A_MODE: mode_r <= reg_wdata_i;
          default: ;
        endcase
      end
      // abnormal stop before advance keeps the failing location
      if (st_r == ST_ADV && !eoc) begin
        sectors_remaining_r <= sectors_remaining_r - 8'h01;
        if (last_sec) begin
          sect_r <= 8'h00;
          if (last_trk) begin
            head_r <= 8'h00;
            cyll_r <= cyll_r + 8'h01;
          end else begin
            head_r <= head_inc;
          end
        end else begin
          sect_r <= sect_inc;
        end
      end
    end
  end

  // error and controller status; a new command clears them except the reset request bit SB_RRQ
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      est_r <= RST_BYTE;
      stat_r <= RST_BYTE;
    end else begin
      if (go_cmd && op_ok) begin
        est_r <= RST_BYTE;
        stat_r <= err_bit(SB_BUSY) | (stat_r & err_bit(SB_RRQ));
      end else begin
        est_r <= est_r | err_set;
        if (rrq_evt) stat_r[SB_RRQ] <= 1'b1;
        if (st_r == ST_ADV && eoc) begin
          est_r[EB_EOC] <= 1'b1;
          stat_r[SB_ABN] <= 1'b1;
        end
        if (st_r == ST_ADV && is_scan && (eoc || cnt_last))
          stat_r[SB_MIS] <= 1'b1;
        if (busy && abn) stat_r[SB_ABN] <= 1'b1;
        if (busy && st_nxt == ST_IDLE) begin
          stat_r[SB_BUSY] <= 1'b0;
          stat_r[SB_DONE] <= 1'b1;
        end
      end
    end
  end

  // scan compare and terminal count latch
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || st_r == ST_IDLE || st_r == ST_ADV) mis_r <= 1'b0;
    else if (byte_in && is_scan && disk_byte_i != cmp_byte)
      mis_r <= 1'b1;
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || st_r == ST_IDLE) tc_r <= 1'b0;
    else if (transfer_count_done_i) tc_r <= 1'b1;
  end

  // dma write data registered; request only on read, before terminal count
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dwr_r <= 1'b0;
      dwdata_r <= RST_BYTE;
    end else begin
      dwr_r <= byte_in && is_read && !tc_r;
      if (byte_in) dwdata_r <= disk_byte_i;
    end
  end
  // scan fetches memory bytes until terminal count, then compares 00
  assign dma_req_o = dwr_r | (byte_in && is_scan && !tc_r);
  assign dma_wdata_o = dwdata_r;
  assign unit_select_o = unit_r;
  assign physical_head_number_o = head_r;
  assign seek_sector_o = st_r == ST_SEEK;

  // read port: data valid the cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr_i)
      A_CMD: rd_mux = {op_r, 2'h0, unit_r};
      A_MARK: rd_mux = mark_r;
      A_CYLH: rd_mux = cylh_r;
      A_CYLL: rd_mux = cyll_r;
      A_HEAD: rd_mux = head_r;
      A_SECT: rd_mux = sect_r;
      A_SECTORS_REMAINING: rd_mux = sectors_remaining_r;
      A_LTRK: rd_mux = ltrk_r;
      A_LSEC: rd_mux = lsec_r;
      A_MODE: rd_mux = mode_r;
      A_EST: rd_mux = est_r;
      A_STAT: rd_mux = stat_r;
      default: rd_mux = RST_BYTE;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) rdata_r <= RST_BYTE;
    else if (reg_rd_i) rdata_r <= rd_mux;
    else rdata_r <= RST_BYTE;
  end
  assign reg_rdata_o = rdata_r;

  chk_eoc_flag: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st_r == ST_ADV && eoc |=> est_r[EB_EOC] && st_r == ST_IDLE)
    else $error("end of cylinder not flagged");
  chk_nr_abort: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    busy && !rdy && !go_cmd |=> est_r[EB_NR] && !busy)
    else $error("not ready did not abort");
  chk_tc_no_dma: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    tc_r && st_r == ST_DATA |=> !dwr_r)
    else $error("dma after terminal count");
  chk_check_nodma: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    op_r == OP_CHECK |-> !dwr_r)
    else $error("check command moved data");
  chk_sectors_remaining_dec: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st_r == ST_ADV && !eoc |=> sectors_remaining_r == $past(sectors_remaining_r) - 8'h01)
    else $error("count not decremented");
  chk_sec_wrap: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st_r == ST_ADV && !eoc && last_sec |=> sect_r == 8'h00)
    else $error("sector did not wrap");
  chk_crc_abort: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st_r == ST_CHK && !ecc_mode && crc_err_i && rdy
    |=> est_r[EB_DER] && stat_r[SB_ABN])
    else $error("crc error not reported");
  chk_busy_lock: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    busy && reg_wr_i && reg_addr_i == A_CMD
    |=> $stable(op_r) && $stable(unit_r))
    else $error("command changed while busy");
  chk_scan_hit: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    scan_hit && !abn |=> st_r == ST_IDLE && $stable(sect_r))
    else $error("scan match location moved");
  chk_ovr_abort: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    byte_in && fifo_full_i && !dma_ack_i && is_read && !tc_r && rdy
    && !flt && !data_mark_miss_i |=> est_r[EB_OVR] && !busy)
    else $error("overrun not reported");
  chk_nd_abort: assert property (
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    st_r == ST_SEEK && idx_rise && id_mark_seen_i && rdy
    && idx_cnt_r == IDX_FIND_LIM - 2'h1 |=> est_r[EB_ND] && !busy)
    else $error("missing sector not reported");
endmodule

//--- bench/drsc_disk_model.sv
// drive, format controller and dma memory model
`timescale 1ns/1ps
module drsc_disk_model #(
  parameter int NB = 4
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // fault to inject and scan mismatch
  input wire logic [3:0] err_i,
  input wire logic miss_i,
  // from the controller
  input wire logic seek_sector_i,
  input wire logic dma_req_i,
  // to the controller
  output logic drv_ready_o,
  output logic drv_fault_o,
  output logic index_pulse_o,
  output logic id_mark_seen_o,
  output logic id_match_o,
  output logic data_mark_miss_o,
  output logic disk_byte_vld_o,
  output logic [7:0] disk_byte_o,
  output logic sector_end_o,
  output logic crc_err_o,
  output logic ecc_err_o,
  output logic ecc_correctable_o,
  output logic dma_ack_o,
  output logic [7:0] dma_rdata_o
);
  logic [1:0] st_r;
  logic [5:0] cnt_r;
  logic [5:0] rot_r;
  // one index pulse per revolution of 64 cycles
  assign index_pulse_o = (rot_r == 6'h00);
  assign id_mark_seen_o = (err_i != 4'h5);
  // check levels are held, the controller samples them once
  assign crc_err_o = (err_i == 4'h1);
  assign ecc_err_o = (err_i == 4'h7) || (err_i == 4'h8);
  assign ecc_correctable_o = (err_i == 4'h7);
  assign drv_fault_o = (err_i == 4'h2) && (st_r == 2'h2);
  assign drv_ready_o = !((err_i == 4'h6) && (st_r == 2'h2));
  // memory answers at once; a miss flips bit 0 of every byte
  assign dma_ack_o = dma_req_i;
  assign dma_rdata_o = disk_byte_o ^ {7'h00, miss_i};
  always @(posedge clk_sys_i) begin
    id_match_o <= 1'b0;
    data_mark_miss_o <= 1'b0;
    disk_byte_vld_o <= 1'b0;
    sector_end_o <= 1'b0;
    // idle data lines toggle so no stale byte looks valid
    disk_byte_o <= ~disk_byte_o;
    rot_r <= rot_r + 6'h01;
    cnt_r <= cnt_r + 6'h01;
    if (sys_rst_i) begin
      st_r <= 2'h0;
      rot_r <= 6'h01;
      disk_byte_o <= 8'h00;
    end else if (st_r == 2'h0) begin
      st_r <= {1'b0, seek_sector_i};
      cnt_r <= 6'h00;
    end else if (st_r == 2'h1) begin
      if (!seek_sector_i) begin
        st_r <= 2'h0;
      end else if (cnt_r == 6'h08 && err_i != 4'h4 && err_i != 4'h5) begin
        id_match_o <= 1'b1;
        st_r <= 2'h2;
        cnt_r <= 6'h00;
      end
    end else if (err_i == 4'h3) begin
      data_mark_miss_o <= 1'b1;
      st_r <= 2'h0;
    end else if (cnt_r == 6'(2 * NB)) begin
      sector_end_o <= 1'b1;
      st_r <= 2'h0;
    end else if (cnt_r[0]) begin
      disk_byte_vld_o <= 1'b1;
      disk_byte_o <= 8'hA0 + {3'h0, cnt_r[5:1]};
    end
  end
endmodule

//--- bench/tb_top.sv
// command level testbench of the read, check and scan logic
`timescale 1ns/1ps
module tb_top;
  import drsc_pkg::*;
  localparam int NB = 4;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tc = 1'b0;
  logic miss = 1'b0;
  logic [3:0] err = 4'h0;
  logic [7:0] head0 = 8'h00;
  logic is_read = 1'b0;
  logic abn;
  logic [7:0] stat, last_b;
  int n_errors = 0;
  int n_checks = 0;
  int n_dma = 0;
  int cyc = 0;
  wire logic [7:0] rdata, disk_byte, dma_rdata, dma_wdata, head_o;
  wire logic [1:0] unit_o;
  wire logic rdy, flt, idx, seen, hit, dmm, vld, s_end, crc, ecc, ecc_ok;
  wire logic dma_req, dma_ack, seek;
  logic [3:0] t_op [9] = '{OP_READ, OP_READ, OP_READ, OP_CHECK,
    OP_READ, OP_READ, OP_READ, OP_READ, OP_READ};
  logic [3:0] t_err [9] = '{4'h1, 4'h7, 4'h8, 4'h7, 4'h2, 4'h3, 4'h4, 4'h6,
    4'h9};
  logic [7:0] t_est [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h40, 8'h02,
    8'h04, 8'h20, 8'h08};
  drsc_core i_drsc_core(.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .drv_ready_i(rdy),
    .drv_fault_i(flt), .index_pulse_i(idx), .unit_select_o(unit_o),
    .physical_head_number_o(head_o), .id_mark_seen_i(seen),
    .id_match_i(hit), .data_mark_miss_i(dmm), .disk_byte_vld_i(vld),
    .disk_byte_i(disk_byte), .sector_end_i(s_end), .crc_err_i(crc),
    .ecc_err_i(ecc), .ecc_correctable_i(ecc_ok), .fifo_full_i(err == 4'h9),
    .dma_req_o(dma_req), .dma_ack_i(dma_ack), .dma_rdata_i(dma_rdata),
    .dma_wdata_o(dma_wdata), .transfer_count_done_i(tc),
    .seek_sector_o(seek));
  drsc_disk_model #(.NB(NB)) i_drsc_disk_model(.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .err_i(err), .miss_i(miss),
    .seek_sector_i(seek), .dma_req_i(dma_req), .drv_ready_o(rdy),
    .drv_fault_o(flt), .index_pulse_o(idx), .id_mark_seen_o(seen),
    .id_match_o(hit), .data_mark_miss_o(dmm), .disk_byte_vld_o(vld),
    .disk_byte_o(disk_byte), .sector_end_o(s_end), .crc_err_o(crc),
    .ecc_err_o(ecc), .ecc_correctable_o(ecc_ok), .dma_ack_o(dma_ack),
    .dma_rdata_o(dma_rdata));
  always #2.5 clk_sys_i = ~clk_sys_i;
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] v);
    n_checks++;
    if (v !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", w, e, v);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, string w);
    logic [7:0] v;
    rd(a, v);
    chk(w, e, v);
  endtask
  // the start head comes from head0 and the last track is always 8
  task automatic run(input logic [3:0] op, input logic [7:0] md,
      input logic [7:0] sc, input logic [7:0] ct, input logic [7:0] ls);
    logic [7:0] s;
    n_dma = 0;
    is_read = (op == OP_READ);
    wr(A_MODE, md);
    wr(A_MARK, 8'h5A);
    wr(A_CYLH, 8'h01);
    wr(A_CYLL, 8'h20);
    wr(A_HEAD, head0);
    wr(A_SECT, sc);
    wr(A_SECTORS_REMAINING, ct);
    wr(A_LTRK, 8'h08);
    wr(A_LSEC, ls);
    wr(A_CMD, {op, 4'h2});
    // a second command while busy must be ignored
    wr(A_CMD, {op ^ 4'h1, 4'h1});
    s = 8'h00;
    for (int i = 0; i < 150 && s[SB_DONE] !== 1'b1; i++) begin
      rd(A_STAT, s);
    end
    stat = s;
    rdchk(A_CMD, {op, 4'h2}, "command");
  endtask
  // each dma write must carry the byte read just before it
  always @(posedge clk_sys_i) begin
    if (vld) last_b <= disk_byte;
    if (dma_req === 1'b1) begin
      n_dma++;
      if (is_read) chk("dma data", last_b, dma_wdata);
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rdchk(A_STAT, RST_BYTE, "stat");
    rdchk(A_EST, RST_BYTE, "est");
    rdchk(4'hF, 8'h00, "unmapped");
    run(OP_READ, 8'h00, 8'h01, 8'h02, 8'h08);
    chk("stat", 8'h02, stat);
    chk("dma count", 8'(2 * NB), 8'(n_dma));
    rdchk(A_SECT, 8'h03, "sector");
    rdchk(A_SECTORS_REMAINING, 8'h00, "count");
    chk("unit", 8'h02, {6'h00, unit_o});
    run(OP_CHECK, 8'h00, 8'h03, 8'h02, 8'h04);
    chk("stat", 8'h02, stat);
    chk("dma count", 8'h00, 8'(n_dma));
    rdchk(A_SECT, 8'h01, "sector");
    rdchk(A_HEAD, 8'h01, "head");
    chk("drive head", 8'h01, head_o);
    run(OP_SCAN, 8'h00, 8'h02, 8'h03, 8'h08);
    chk("stat", 8'h02, stat);
    rdchk(A_SECT, 8'h02, "sector");
    rdchk(A_CYLL, 8'h20, "cylinder");
    miss <= 1'b1;
    run(OP_SCAN, 8'h00, 8'h02, 8'h02, 8'h08);
    chk("mismatch", 8'h01, {7'h00, stat[SB_MIS]});
    rdchk(A_SECTORS_REMAINING, 8'h00, "count");
    miss <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      err <= t_err[i];
      run(t_op[i], (t_err[i] > 4'h6) ? 8'h01 : 8'h00, 8'h03, 8'h01, 8'h08);
      rdchk(A_EST, t_est[i], "est");
      abn = (t_err[i] != 4'h7) || (t_op[i] == OP_CHECK);
      chk("stat", abn ? 8'h06 : 8'h02, stat);
      if (abn) rdchk(A_SECT, 8'h03, "error sector");
      err <= 4'h0;
      repeat (8) @(posedge clk_sys_i);
    end
    // last sector of the last track: one sector wraps into the next cylinder
    head0 = 8'h07;
    run(OP_READ, 8'h00, 8'h07, 8'h01, 8'h08);
    chk("stat", 8'h02, stat);
    rdchk(A_CYLL, 8'h21, "cylinder");
    rdchk(A_HEAD, 8'h00, "head");
    run(OP_READ, 8'h00, 8'h07, 8'h02, 8'h08);
    rdchk(A_EST, 8'h80, "end of cylinder");
    chk("stat", 8'h06, stat);
    rdchk(A_SECT, 8'h07, "error sector");
    head0 = 8'h00;
    tc <= 1'b1;
    run(OP_READ, 8'h00, 8'h01, 8'h02, 8'h08);
    chk("dma count", 8'h00, 8'(n_dma));
    rdchk(A_SECT, 8'h03, "sector");
    run(OP_SCAN, 8'h00, 8'h01, 8'h01, 8'h08);
    chk("mismatch", 8'h01, {7'h00, stat[SB_MIS]});
    tc <= 1'b0;
    err <= 4'h5;
    run(OP_READ, 8'h00, 8'h01, 8'h01, 8'h08);
    chk("reset request", 8'h01, {7'h00, stat[SB_RRQ]});
    err <= 4'h0;
    sys_rst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rdchk(A_STAT, RST_BYTE, "stat after reset");
    report_and_stop();
  end
endmodule
